// ===== rtl/ldr_pkg.sv
// Package for the display RAM write path: modes, geometry and reset values.
// Assumes a single system clock and an upstream bus decoder that frames bytes.
package ldr_pkg;

    typedef enum logic [1:0] {
        LDR_MUX_1TO4,
        LDR_MUX_1TO6,
        LDR_MUX_1TO8,
        LDR_MUX_RSVD
    } ldr_mux_t;

    typedef enum logic [1:0] {
        LDR_BIAS_HALF,
        LDR_BIAS_THIRD,
        LDR_BIAS_QUARTER,
        LDR_BIAS_RSVD
    } ldr_bias_t;

    localparam int unsigned LDR_SEG_COUNT   = 44;
    localparam int unsigned LDR_BP_COUNT    = 8;
    localparam int unsigned LDR_GPO_COUNT   = 6;
    localparam int unsigned LDR_RAM_BITS    = 320;
    localparam int unsigned LDR_PTR_W       = 9;
    localparam logic [8:0]  LDR_END_1TO4    = 9'h0_0b0;
    localparam logic [8:0]  LDR_END_1TO6    = 9'h0_0fc;
    localparam logic [8:0]  LDR_END_1TO8    = 9'h0_140;
    localparam logic [8:0]  LDR_PTR_RESET   = 9'h0_000;
    localparam logic [1:0]  LDR_RS_RAM      = 2'h1;
    localparam logic [2:0]  LDR_H_1TO4      = 3'h4;
    localparam logic [2:0]  LDR_H_1TO6      = 3'h6;
    localparam logic [3:0]  LDR_H_1TO8      = 4'h8;
    localparam logic [7:0]  LDR_PHASE_RESET = 8'h01;

endpackage : ldr_pkg

// ===== rtl/ldr_display_ram.sv
// Display RAM, bit-granular data pointer, display register and backplane scan.
// Assumes the bus decoder delivers one-cycle strobes; the host owns pointer reloads.
// Notes on behaviour
// - 1:6 mode uses six backplanes and accepts third or quarter bias.
// - Backplanes 0-7, 0-5 or 0-3 are active in 1:8, 1:6, 1:4 modes.
// - Up to 44 segment outputs driven by display register and backplane timing.
// - A display register holds data while the multiplex signals are generated.
// - Each enabled general purpose output replaces its low-numbered segment output.
// - RAM is 40x8, 42x6 or 44x4 depending on multiplex mode.
// - RAM bit one means element on, zero means element off.
// - Row n pairs with backplane n, column n drives segment n.
// - Pointer command starts a write; next byte lands at the pointer.
// - Pointer advances two, one and a third, or one column per byte in 1:4, 1:6, 1:8 modes.
// - At RAM end the pointer stops; surplus bits and bytes are dropped.
// - In 1:4 mode a byte fills two columns; 22 bytes fill RAM.
// - In 1:6 mode bits complete a column then wrap into the next.
// - In 1:8 mode a byte fills exactly one column; 40 bytes fill RAM.
// - Data bytes reach RAM only when the register selection field is 01.
`timescale 1ns/100ps
module ldr_display_ram (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        arst_n,
    // Configuration
    input  wire ldr_pkg::ldr_mux_t           mux_mode,
    input  wire ldr_pkg::ldr_bias_t          bias_mode,
    input  wire logic [5:0]                  gpo_enable,
    input  wire logic [5:0]                  general_purpose_outputs_in,
    // Bus decoder side
    input  wire logic [1:0]                  register_selection_field,
    input  wire logic                        set_ram_pointer_command,
    input  wire logic [5:0]                  pointer_column,
    input  wire logic [2:0]                  pointer_row,
    input  wire logic                        data_valid,
    input  wire logic [7:0]                  data_byte,
    // Multiplex timing
    input  wire logic                        frame_step,
    // LCD side
    output logic      [7:0]                  backplane_outputs,
    output logic      [43:0]                 segment_outputs,
    output logic      [5:0]                  general_purpose_outputs,
    output logic                             bias_valid,
    output logic                             pointer_at_end
);
    import ldr_pkg::*;

    // Flat bit store, addressed as column * height + row.
    logic [LDR_RAM_BITS-1:0] ram_reg;
    logic [8:0]              ptr_reg;
    logic [8:0]              ptr_next;
    logic [7:0]              phase_reg;
    logic [2:0]              row_reg;
    logic [43:0]             disp_reg;
    logic [43:0]             seg_next;
    logic [7:0]              bp_reg;
    logic [43:0]             seg_reg;
    logic [5:0]              gpo_reg;

    wire logic [3:0] col_height = (mux_mode == LDR_MUX_1TO8) ? LDR_H_1TO8 :
                                  (mux_mode == LDR_MUX_1TO6) ? {1'b0, LDR_H_1TO6} :
                                  {1'b0, LDR_H_1TO4};
    wire logic [8:0] ram_end    = (mux_mode == LDR_MUX_1TO8) ? LDR_END_1TO8 :
                                  (mux_mode == LDR_MUX_1TO6) ? LDR_END_1TO6 :
                                  LDR_END_1TO4;
    wire logic [2:0] last_row   = 3'(col_height - 4'h1);
    wire logic       write_ok   = data_valid && (register_selection_field == LDR_RS_RAM);
    wire logic       at_end     = (ptr_reg >= ram_end);
    wire logic [8:0] load_addr  = 9'(pointer_column * col_height) + 9'(pointer_row);
    wire logic [8:0] room       = at_end ? 9'h0_000 : 9'(ram_end - ptr_reg);
    wire logic [8:0] byte_step  = (room < 9'h0_008) ? room : 9'h0_008;
    wire logic       bias_ok    = (mux_mode != LDR_MUX_1TO6) ||
                                  (bias_mode == LDR_BIAS_THIRD) ||
                                  (bias_mode == LDR_BIAS_QUARTER);

    // Each byte advances eight bit positions, fewer near the RAM end: two columns of four, one of eight,
    // or one-plus-part of six, which is where the bit granularity pays off.
    always_comb begin
        ptr_next = ptr_reg;
        if (set_ram_pointer_command) begin
            ptr_next = (load_addr > ram_end) ? ram_end : load_addr;
        end else if (write_ok) begin
            ptr_next = 9'(ptr_reg + byte_step);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_reg <= LDR_PTR_RESET;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    // Bit k of the byte goes to address ptr+k; addresses past the end are dropped.
    // The per-bit decode is combinational so that the whole store has one
    // clocked process and therefore one driver.
    wire logic [LDR_RAM_BITS-1:0] hit_vec;
    wire logic [LDR_RAM_BITS-1:0] ram_next;

    genvar gi;
    generate
        for (gi = 0; gi < LDR_RAM_BITS; gi++) begin : g_bit
            wire logic [8:0] rel = 9'(gi) - ptr_reg;
            assign hit_vec[gi]  = write_ok && !set_ram_pointer_command &&
                                  (9'(gi) >= ptr_reg) && (rel < byte_step);
            assign ram_next[gi] = hit_vec[gi] ? data_byte[rel[2:0]] : ram_reg[gi];
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ram_reg <= '0;
        end else begin
            ram_reg <= ram_next;
        end
    end

    // Scan: phase is one-hot over the active rows; it wraps at the mode height.
    wire logic       row_wrap = (row_reg >= last_row);
    wire logic [2:0] row_next = row_wrap ? 3'h0 : 3'(row_reg + 3'h1);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            row_reg   <= 3'h0;
            phase_reg <= LDR_PHASE_RESET;
        end else if (frame_step) begin
            row_reg   <= row_next;
            phase_reg <= 8'h01 << row_next;
        end
    end

    // The display register captures the next row at each step so that a RAM
    // write in mid-frame never tears the row currently on the glass.
    always_comb begin
        seg_next = '0;
        for (int c = 0; c < LDR_SEG_COUNT; c++) begin
            if (9'(c) * 9'(col_height) < ram_end) begin
                seg_next[c] = ram_reg[9'(c) * 9'(col_height) + 9'(row_next)];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            disp_reg <= '0;
        end else if (frame_step) begin
            disp_reg <= seg_next;
        end
    end

    // Segments beyond the mode's column count stay off; enabled GPOs take over
    // the lowest segments and those segment pins rest low.
    wire logic [43:0] seg_mask = {{38{1'b1}}, ~gpo_enable};

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bp_reg  <= 8'h00;
            seg_reg <= '0;
            gpo_reg <= 6'h00;
        end else begin
            bp_reg  <= phase_reg;
            seg_reg <= disp_reg & seg_mask;
            gpo_reg <= general_purpose_outputs_in & gpo_enable;
        end
    end

    assign backplane_outputs       = bp_reg;
    assign segment_outputs         = seg_reg;
    assign general_purpose_outputs = gpo_reg;
    assign bias_valid              = bias_ok;
    assign pointer_at_end          = at_end;

    // Host side duties: reload after end and after an aborted transfer.

    stop_at_end_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        at_end && !set_ram_pointer_command |=> $stable(ptr_reg))
        else $error("pointer moved past the end of RAM");

    step_eight_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        write_ok && !set_ram_pointer_command && (ptr_reg + 9'h8 <= ram_end)
        |=> ptr_reg == $past(ptr_reg) + 9'h8)
        else $error("pointer did not advance one byte");

    rs_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !set_ram_pointer_command && (register_selection_field != LDR_RS_RAM)
        |=> $stable(ptr_reg) && $stable(ram_reg))
        else $error("non RAM data changed the display RAM");

    load_ptr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        set_ram_pointer_command && (load_addr <= ram_end) |=> ptr_reg == $past(load_addr))
        else $error("pointer load lost");

    bp_onehot_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        frame_step ##1 1'b1 |=> $onehot(backplane_outputs))
        else $error("backplanes not one hot");

    // A mode change leaves the row where it was until the next step, so the
    // range is only judged right after a step taken in the mode itself.
    bp_range_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $past(frame_step) && ($past(mux_mode) == LDR_MUX_1TO4) |-> row_reg <= 3'h3)
        else $error("1:4 scan left rows 0 to 3");

    bp_range6_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $past(frame_step) && ($past(mux_mode) == LDR_MUX_1TO6) |-> row_reg <= 3'h5)
        else $error("1:6 scan left rows 0 to 5");

    load_clamp_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        set_ram_pointer_command && (load_addr > ram_end) |=> ptr_reg == $past(ram_end))
        else $error("pointer load beyond end not clamped");

    load_wins_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        set_ram_pointer_command |=> $stable(ram_reg))
        else $error("byte written in a pointer load cycle");

    tail_drop_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        write_ok && !set_ram_pointer_command && (ptr_reg <= ram_end) &&
        (ptr_reg + 9'h8 > ram_end) |=> ptr_reg == $past(ram_end))
        else $error("pointer did not stop at the end of RAM");

    idle_ram_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !data_valid |=> $stable(ram_reg))
        else $error("display RAM changed without a byte");

    idle_ptr_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !data_valid && !set_ram_pointer_command |=> $stable(ptr_reg))
        else $error("pointer moved without a byte or load");

    // Segments past the mode's column count must read off two cycles after a step.
    seg_tail8_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $past(frame_step, 2) && ($past(mux_mode, 2) == LDR_MUX_1TO8)
        |-> segment_outputs[43:40] == 4'h0)
        else $error("segment beyond column 39 active in 1:8");

    seg_tail6_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $past(frame_step, 2) && ($past(mux_mode, 2) == LDR_MUX_1TO6)
        |-> segment_outputs[43:42] == 2'h0)
        else $error("segment beyond column 41 active in 1:6");

    bias_half6_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mux_mode == LDR_MUX_1TO6) && (bias_mode == LDR_BIAS_HALF) |-> !bias_valid)
        else $error("half bias accepted in 1:6");

    gpo_replace_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ##1 ((segment_outputs[5:0] & $past(gpo_enable)) == 6'h00))
        else $error("segment active under an enabled GENERAL_PURPOSE_OUTPUT");

    disp_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !frame_step |=> $stable(disp_reg))
        else $error("display register changed between steps");

endmodule : ldr_display_ram

// ===== tb/ldr_host_model.sv
// Host side model: pointer loads and display bytes as one-cycle strobes.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/100ps
module ldr_host_model (
    // Clock
    input  wire logic       sys_clk,
    // Decoder strobes
    output logic [1:0] register_selection_field,
    output logic       set_ram_pointer_command,
    output logic [5:0] pointer_column,
    output logic [2:0] pointer_row,
    output logic       data_valid,
    output logic [7:0] data_byte
);
    initial begin
        {register_selection_field, set_ram_pointer_command, pointer_column} = '0;
        {pointer_row, data_valid, data_byte} = '0;
    end
    // Every write burst starts with a pointer load.
    task automatic load(input logic [5:0] c, input logic [2:0] r);
        @(posedge sys_clk);
        set_ram_pointer_command <= 1'b1;
        data_valid              <= 1'b0;
        pointer_column          <= c;
        pointer_row             <= r;
        @(posedge sys_clk);
        set_ram_pointer_command <= 1'b0;
        pointer_column          <= ~c;
    endtask : load
    task automatic put(input logic [1:0] f, input logic [7:0] b);
        @(posedge sys_clk);
        register_selection_field <= f;
        data_valid               <= 1'b1;
        data_byte                <= b;
    endtask : put
    // A released byte lane shows the inverse of its last value.
    task automatic idle();
        @(posedge sys_clk);
        data_valid <= 1'b0;
        data_byte  <= ~data_byte;
    endtask : idle
endmodule : ldr_host_model

// ===== tb/lcd_display_ram_pointer_tb_top.sv
// Bench for the display RAM write path; a flat bit model predicts the scan.
// Assumes the host model drives the decoder strobes.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected %0t compare mismatch", $time); end end
module lcd_display_ram_pointer_tb_top;
    import ldr_pkg::*;
    logic sys_clk = 0, arst_n = 0, frame_step = 0;
    ldr_mux_t mux_mode = LDR_MUX_1TO8;
    ldr_bias_t bias_mode = LDR_BIAS_THIRD;
    logic [5:0] gpo_enable = '0, gpo_in = '0, gpo_out;
    logic [1:0] rsf;
    logic set_ptr, dv, bias_valid, at_end;
    logic [5:0] pcol;
    logic [2:0] prow;
    logic [7:0] db, bp;
    logic [43:0] seg;
    logic exp_bits [320];
    int n_fail = 0, n_tests = 0, ptr = 0, h = 8, nb = 320;
    always #2.5 sys_clk = ~sys_clk;
    ldr_host_model ldr_host_model_i (.sys_clk(sys_clk), .register_selection_field(rsf),
        .set_ram_pointer_command(set_ptr), .pointer_column(pcol), .pointer_row(prow),
        .data_valid(dv), .data_byte(db));
    ldr_display_ram ldr_display_ram_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .mux_mode(mux_mode), .bias_mode(bias_mode), .gpo_enable(gpo_enable),
        .general_purpose_outputs_in(gpo_in), .register_selection_field(rsf),
        .set_ram_pointer_command(set_ptr), .pointer_column(pcol), .pointer_row(prow),
        .data_valid(dv), .data_byte(db), .frame_step(frame_step), .backplane_outputs(bp),
        .segment_outputs(seg), .general_purpose_outputs(gpo_out), .bias_valid(bias_valid),
        .pointer_at_end(at_end));
    task automatic set_mode(input ldr_mux_t m, input int hh);
        @(posedge sys_clk) mux_mode <= m;
        h  = hh;
        nb = (hh == 8) ? 320 : (hh == 6) ? 252 : 176;
    endtask : set_mode
    task automatic load(input int c, input int r);
        ldr_host_model_i.load(c, r);
        ptr = (c * h + r > nb) ? nb : c * h + r;
    endtask : load
    // Bits beyond the end of the RAM are dropped in the model as well.
    task automatic put(input logic [1:0] f, input logic [7:0] b);
        ldr_host_model_i.put(f, b);
        if (f == LDR_RS_RAM) for (int k = 0; k < 8; k++) if (ptr < nb) begin
            exp_bits[ptr] = b[k];
            ptr++;
        end
    endtask : put
    task automatic scan(input int nc);
        int r;
        repeat (h) begin
            @(posedge sys_clk) frame_step <= 1'b1;
            @(posedge sys_clk) frame_step <= 1'b0;
            repeat (3) @(posedge sys_clk);
            #1 r = -1;
            for (int i = 0; i < 8; i++) if (bp[i] === 1'b1) r = i;
            `CHK(r >= 0 && r < h && $countones(bp) == 1, 1'b1)
            if (r >= 0) for (int c = 0; c < nc; c++)
                `CHK(seg[c], (c < 6 && gpo_enable[c]) ? 1'b0 : exp_bits[c * h + r])
        end
    endtask : scan
    task automatic t_fill8();
        set_mode(LDR_MUX_1TO8, 8);
        load(0, 0);
        for (int i = 0; i < 41; i++) put(LDR_RS_RAM, 8'(i * 37 + 5));
        ldr_host_model_i.idle();
        @(posedge sys_clk) #1;
        `CHK(at_end, 1'b1)
        scan(40);
    endtask : t_fill8
    task automatic t_fill4();
        set_mode(LDR_MUX_1TO4, 4);
        load(3, 0);
        put(2'h0, 8'hff);
        put(2'h2, 8'hff);
        for (int i = 0; i < 21; i++) put(LDR_RS_RAM, 8'(i * 53 + 9));
        ldr_host_model_i.idle();
        scan(44);
    endtask : t_fill4
    task automatic t_wrap6();
        set_mode(LDR_MUX_1TO6, 6);
        load(40, 3);
        put(LDR_RS_RAM, 8'ha5);
        put(LDR_RS_RAM, 8'h3c);
        load(5, 2);
        put(LDR_RS_RAM, 8'h96);
        ldr_host_model_i.idle();
        scan(42);
        @(posedge sys_clk) bias_mode <= LDR_BIAS_HALF;
        @(posedge sys_clk) #1;
        `CHK(bias_valid, 1'b0)
        @(posedge sys_clk) bias_mode <= LDR_BIAS_QUARTER;
        @(posedge sys_clk) #1;
        `CHK(bias_valid, 1'b1)
    endtask : t_wrap6
    task automatic t_gpo();
        set_mode(LDR_MUX_1TO4, 4);
        @(posedge sys_clk) gpo_enable <= 6'h25;
        gpo_in <= 6'h37;
        repeat (3) @(posedge sys_clk);
        #1 `CHK(gpo_out, 6'h25)
        scan(44);
    endtask : t_gpo
    task automatic end_of_test();
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial begin
        for (int i = 0; i < 320; i++) exp_bits[i] = 1'b0;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_fill8();
        t_fill4();
        t_wrap6();
        t_gpo();
        end_of_test();
    end
    initial begin
        #50us n_fail++;
        end_of_test();
    end
endmodule : lcd_display_ram_pointer_tb_top
